// ===== pkg/pmcu_pkg.sv
// constants and types for the power management clock unit
// assumes a single 40 MHz system clock and an apb register bus
package pmcu_pkg;
  // register indexes; the bus sees one aligned word per index
  localparam logic [9:0] IDX_EXTENDED_IRQ_FLAG_CLOCK_CLK = 10'h091;
  localparam logic [9:0] IDX_PM_CTRL = 10'h0c4;
  localparam logic [9:0] IDX_SVC_STAT = 10'h0c5;
  localparam logic [11:0] ADDR_EXTENDED_IRQ_FLAG_CLOCK_CLK = {IDX_EXTENDED_IRQ_FLAG_CLOCK_CLK, 2'b00};
  localparam logic [11:0] ADDR_PM_CTRL = {IDX_PM_CTRL, 2'b00};
  localparam logic [11:0] ADDR_SVC_STAT = {IDX_SVC_STAT, 2'b00};
  localparam int unsigned DIVSEL_HI_BIT = 7;
  localparam int unsigned DIVSEL_LO_BIT = 6;
  localparam int unsigned AUTORET_BIT = 5;
  localparam int unsigned XOFF_BIT = 3;
  localparam int unsigned SRCSEL_BIT = 3;
  localparam int unsigned RINGST_BIT = 2;
  localparam int unsigned XREADY_BIT = 4;
  localparam logic [1:0] DIV_RSVD = 2'h0;
  localparam logic [1:0] DIV_4 = 2'h1;
  localparam logic [1:0] DIV_64 = 2'h2;
  localparam logic [1:0] DIV_1024 = 2'h3;
  localparam logic [1:0] DIV_RESET = DIV_4;
  localparam logic [10:0] CNT_4 = 11'h004;
  localparam logic [10:0] CNT_64 = 11'h040;
  localparam logic [10:0] CNT_1024 = 11'h400;
  localparam int unsigned WARMUP_CLOCKS = 65536;
  typedef enum logic [1:0] {
    XS_RUN = 2'b00,
    XS_WARM = 2'b01,
    XS_OFF = 2'b11
  } xtal_state_t;
endpackage

// ===== pkg/cyc_if.sv
// divider interface between the clock unit and its cycle divider
// assumes one clock domain
`timescale 1ns/1ps
interface cyc_if;
  logic [1:0] code;
  logic tick;
  modport ctrl (output code, input tick);
  modport div (input code, output tick);
endinterface

// ===== rtl/pmcu_cycle_div.sv
// instruction cycle enable generator
// assumes code is one of the legal divider values
`timescale 1ns/1ps
module pmcu_cycle_div (
  input wire logic clk,
  input wire logic rst_n,
  cyc_if.div cif
);
  import pmcu_pkg::*;
  logic [10:0] cnt_r;
  logic [10:0] limit;
  logic wrap;
  assign limit = (cif.code == DIV_1024) ? CNT_1024 :
                 (cif.code == DIV_64) ? CNT_64 : CNT_4;
  assign wrap = (cnt_r >= limit - 11'h001);
  assign cif.tick = wrap;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 11'h000;
    end else begin
      cnt_r <= wrap ? 11'h000 : cnt_r + 11'h001;
    end
  end
endmodule

// ===== rtl/pmcu_sync.sv
// three stage synchroniser with agreement filter for a pin level
// assumes asynchronous input
`timescale 1ns/1ps
module pmcu_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic din,
  output logic dout
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        dout <= s3_r;
      end
    end
  end
endmodule

// ===== rtl/pmcu_top.sv
// power management clock unit: divider, source select, crystal gate
// assumes apb master; serial/interrupt event inputs are on CLK_SYS
// crystal oscillation start arrives asynchronously and is synchronised
`timescale 1ns/1ps
module pmcu_top #(
  parameter int unsigned WARMUP = pmcu_pkg::WARMUP_CLOCKS
) (
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic XTAL_OSC_RUNNING,
  input wire logic EXT_IRQ_PENDING,
  input wire logic EXT_IRQ_HIGH_PRIO,
  input wire logic POWERFAIL_LEVEL_ACTIVE,
  input wire logic HIGH_LEVEL_ACTIVE,
  input wire logic LOW_LEVEL_ACTIVE,
  input wire logic SERIAL0_RX_ENABLE,
  input wire logic SERIAL1_RX_ENABLE,
  input wire logic SERIAL0_START_EDGE,
  input wire logic SERIAL1_START_EDGE,
  input wire logic SERIAL0_TX_BUFFER_WRITE,
  input wire logic SERIAL1_TX_BUFFER_WRITE,
  input wire logic SERIAL0_RX_ACTIVE,
  input wire logic SERIAL0_TX_ACTIVE,
  input wire logic SERIAL1_RX_ACTIVE,
  input wire logic SERIAL1_TX_ACTIVE,
  output logic CYCLE_TICK,
  output logic [1:0] DIVIDER_ACTIVE,
  output logic RING_ACTIVE_STATUS,
  output logic CRYSTAL_AMP_DISABLE,
  output logic CRYSTAL_READY
);
  import pmcu_pkg::*;

  localparam logic [16:0] WARM_LAST = 17'(WARMUP - 1);

  cyc_if cif ();

  // control registers
  logic [1:0] div_sel_r;
  logic [1:0] div_sel_nxt;
  logic [1:0] div_act_r;
  logic auto_ret_r;
  logic auto_ret_nxt;
  logic xoff_r;
  logic xoff_nxt;
  logic src_sel_r;
  logic src_sel_nxt;
  logic src_act_r;
  logic xready_r;
  logic [16:0] warm_cnt_r;
  xtal_state_t xstate_r;
  xtal_state_t xstate_nxt;
  logic osc_run;

  pmcu_sync u_osc_sync (
    .clk(CLK_SYS),
    .rst_n(RESET_N),
    .din(XTAL_OSC_RUNNING),
    .dout(osc_run)
  );

  pmcu_cycle_div u_div (
    .clk(CLK_SYS),
    .rst_n(RESET_N),
    .cif(cif)
  );

  function automatic logic hit(input logic [11:0] a, input logic [11:0] b);
    return a == b;
  endfunction

  // apb decode: zero wait states, unmapped addresses answer with an error
  logic wr_acc;
  logic rd_acc;
  logic sel_extended_irq_flag_clock;
  logic sel_pm;
  logic sel_stat;
  logic mapped;
  assign sel_extended_irq_flag_clock = hit(PADDR, ADDR_EXTENDED_IRQ_FLAG_CLOCK_CLK);
  assign sel_pm = hit(PADDR, ADDR_PM_CTRL);
  assign sel_stat = hit(PADDR, ADDR_SVC_STAT);
  assign mapped = sel_extended_irq_flag_clock | sel_pm | sel_stat;
  assign wr_acc = PSEL & ~PENABLE & PWRITE & mapped;
  assign rd_acc = PSEL & ~PENABLE & ~PWRITE;

  // write qualification on the setup cycle so effects line up with answer
  logic [1:0] wr_div;
  logic div_legal;
  logic wr_pm;
  logic wr_extended_irq_flag_clock;
  logic set_src;
  assign wr_pm = wr_acc & sel_pm;
  assign wr_extended_irq_flag_clock = wr_acc & sel_extended_irq_flag_clock;
  assign wr_div = {PWDATA[DIVSEL_HI_BIT], PWDATA[DIVSEL_LO_BIT]};
  assign div_legal = (wr_div == DIV_4) |
                     ((wr_div != DIV_RSVD) & (div_act_r == DIV_4));
  assign set_src = PWDATA[SRCSEL_BIT];

  // auto return trigger
  logic irq_ok;
  logic start_hit;
  logic tx_hit;
  logic auto_ret;
  // a low priority source cannot preempt any level in service
  assign irq_ok = EXT_IRQ_PENDING & ~POWERFAIL_LEVEL_ACTIVE &
                  (EXT_IRQ_HIGH_PRIO ? ~HIGH_LEVEL_ACTIVE :
                   ~(HIGH_LEVEL_ACTIVE | LOW_LEVEL_ACTIVE));
  // start edge works on the ring too; baud accuracy is the user's concern
  assign start_hit = (SERIAL0_START_EDGE & SERIAL0_RX_ENABLE) |
                     (SERIAL1_START_EDGE & SERIAL1_RX_ENABLE);
  assign tx_hit = SERIAL0_TX_BUFFER_WRITE | SERIAL1_TX_BUFFER_WRITE;
  assign auto_ret = auto_ret_r & (irq_ok | start_hit | tx_hit);

  // divider selection; hardware return wins over a software write
  always_comb begin
    div_sel_nxt = div_sel_r;
    if (wr_pm & div_legal) begin
      div_sel_nxt = wr_div;
    end
    if (auto_ret) begin
      div_sel_nxt = DIV_4;
    end
  end

  assign auto_ret_nxt = wr_pm ? PWDATA[AUTORET_BIT] : auto_ret_r;

  // crystal off accepted only with ring selected; clearing always allowed
  always_comb begin
    xoff_nxt = xoff_r;
    if (wr_pm) begin
      if (!PWDATA[XOFF_BIT]) begin
        xoff_nxt = 1'b0;
      end else if (!src_sel_r) begin
        xoff_nxt = 1'b1;
      end
    end
  end

  // crystal selection refused until crystal stable and amplifier enabled
  always_comb begin
    src_sel_nxt = src_sel_r;
    if (wr_extended_irq_flag_clock) begin
      if (!set_src) begin
        src_sel_nxt = 1'b0;
      end else if (xready_r & ~xoff_r) begin
        src_sel_nxt = 1'b1;
      end
    end
  end

  // crystal warm-up sequence
  logic warm_done;
  assign warm_done = (warm_cnt_r == WARM_LAST);
  always_comb begin
    xstate_nxt = xstate_r;
    case (xstate_r)
      XS_RUN: begin
        if (xoff_r) begin
          xstate_nxt = XS_OFF;
        end
      end
      XS_OFF: begin
        if (!xoff_r) begin
          xstate_nxt = XS_WARM;
        end
      end
      XS_WARM: begin
        if (xoff_r) begin
          xstate_nxt = XS_OFF;
        end else if (osc_run & warm_done) begin
          xstate_nxt = XS_RUN;
        end
      end
      default: begin
        xstate_nxt = XS_RUN;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      div_sel_r <= DIV_RESET;
      auto_ret_r <= 1'b0;
      xoff_r <= 1'b0;
      src_sel_r <= 1'b1;
      xstate_r <= XS_RUN;
    end else begin
      div_sel_r <= div_sel_nxt;
      auto_ret_r <= auto_ret_nxt;
      xoff_r <= xoff_nxt;
      src_sel_r <= src_sel_nxt;
      xstate_r <= xstate_nxt;
    end
  end

  // warm-up counts oscillator clocks, seen as system clocks once running
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      warm_cnt_r <= 17'h0_0000;
    end else if (xstate_r != XS_WARM) begin
      warm_cnt_r <= 17'h0_0000;
    end else if (osc_run & ~warm_done) begin
      warm_cnt_r <= warm_cnt_r + 17'h0_0001;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      xready_r <= 1'b1;
    end else begin
      xready_r <= (xstate_nxt == XS_RUN);
    end
  end

  // applied divider and source move only on an instruction cycle boundary,
  // which delays a new selection by up to one instruction cycle
  assign cif.code = div_act_r;
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      div_act_r <= DIV_RESET;
      src_act_r <= 1'b1;
    end else if (cif.tick) begin
      div_act_r <= div_sel_r;
      if (xready_r & ~xoff_r) begin
        src_act_r <= src_sel_r;
      end else begin
        src_act_r <= 1'b0;
      end
    end
  end

  // read mux
  logic [7:0] extended_irq_flag_clock_rd;
  logic [7:0] pm_rd;
  logic [7:0] stat_rd;
  logic [31:0] rd_mux;
  assign extended_irq_flag_clock_rd = {4'h0, src_sel_r, ~src_act_r, 2'h0};
  assign pm_rd = {div_sel_r, auto_ret_r, 1'b0, xoff_r, 3'h0};
  assign stat_rd = {POWERFAIL_LEVEL_ACTIVE, HIGH_LEVEL_ACTIVE, LOW_LEVEL_ACTIVE,
                    xready_r,
                    SERIAL1_TX_ACTIVE, SERIAL1_RX_ACTIVE,
                    SERIAL0_TX_ACTIVE, SERIAL0_RX_ACTIVE};
  assign rd_mux = sel_extended_irq_flag_clock ? {24'h00_0000, extended_irq_flag_clock_rd} :
                  sel_pm ? {24'h00_0000, pm_rd} :
                  sel_stat ? {24'h00_0000, stat_rd} : 32'h0000_0000;

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      PRDATA <= 32'h0000_0000;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= PSEL & ~PENABLE;
      PSLVERR <= PSEL & ~PENABLE & ~mapped;
      if (rd_acc) begin
        PRDATA <= rd_mux;
      end
    end
  end

  // outputs registered; the tick is the enable for timers and baud logic
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      CYCLE_TICK <= 1'b0;
      DIVIDER_ACTIVE <= DIV_RESET;
      RING_ACTIVE_STATUS <= 1'b0;
      CRYSTAL_AMP_DISABLE <= 1'b0;
      CRYSTAL_READY <= 1'b1;
    end else begin
      CYCLE_TICK <= cif.tick;
      DIVIDER_ACTIVE <= div_act_r;
      RING_ACTIVE_STATUS <= ~src_act_r;
      CRYSTAL_AMP_DISABLE <= xoff_r;
      CRYSTAL_READY <= xready_r;
    end
  end
endmodule

// ===== bench/pmcu_top_properties.sv
// checks on the clock unit top ports
// bound into pmcu_top; one clock, async low reset
`timescale 1ns/1ps
module pmcu_top_properties
  import pmcu_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic CYCLE_TICK,
  input wire logic [1:0] DIVIDER_ACTIVE,
  input wire logic RING_ACTIVE_STATUS,
  input wire logic CRYSTAL_AMP_DISABLE,
  input wire logic CRYSTAL_READY
);
  default clocking @(posedge CLK_SYS);
  endclocking
  default disable iff (!RESET_N);
  AST_RST_DIV: assert property ($rose(RESET_N) |-> DIVIDER_ACTIVE == DIV_4)
    else $error("reset divider");
  AST_RST_XTAL: assert property ($rose(RESET_N) |-> CRYSTAL_READY && !RING_ACTIVE_STATUS)
    else $error("reset source");
  AST_NO_RSVD: assert property (DIVIDER_ACTIVE != DIV_RSVD)
    else $error("reserved divider");
  AST_VIA_FOUR: assert property (
    $changed(DIVIDER_ACTIVE) && DIVIDER_ACTIVE != DIV_4 |-> $past(DIVIDER_ACTIVE) == DIV_4)
    else $error("direct reduced change");
  AST_TICK_FOUR: assert property (
    CYCLE_TICK ##1 (!CYCLE_TICK && DIVIDER_ACTIVE == DIV_4) [*3] |=> CYCLE_TICK)
    else $error("tick spacing");
  // a divider change must follow an instruction cycle boundary, never the write
  AST_AT_TICK: assert property (
    $changed(DIVIDER_ACTIVE) |-> CYCLE_TICK || $past(CYCLE_TICK) || $past(CYCLE_TICK, 2))
    else $error("divider off tick");
  AST_READY_DROP: assert property ($fell(CRYSTAL_READY) |-> CRYSTAL_AMP_DISABLE)
    else $error("ready drop");
  AST_TO_XTAL: assert property (
    $fell(RING_ACTIVE_STATUS) |-> CRYSTAL_READY && !CRYSTAL_AMP_DISABLE)
    else $error("crystal not ready");
  cover property (DIVIDER_ACTIVE == DIV_1024);
  cover property ($rose(CRYSTAL_READY));
  cover property ($rose(RING_ACTIVE_STATUS));
endmodule
bind pmcu_top pmcu_top_properties i_pmcu_top_properties (.CLK_SYS, .RESET_N, .CYCLE_TICK,
  .DIVIDER_ACTIVE, .RING_ACTIVE_STATUS, .CRYSTAL_AMP_DISABLE, .CRYSTAL_READY);

// ===== bench/tb_power_manage_clock_unit.sv
// self-checking bench for the power management clock unit
// drives every port itself; warm-up shortened to WU clocks
`timescale 1ns/1ps
module tb_power_manage_clock_unit;
  import pmcu_pkg::*;
  localparam int unsigned WU = 16;
  logic CLK_SYS, RESET_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic XTAL_OSC_RUNNING = 1'b1, hp = 1'b0, PREADY, PSLVERR, CYCLE_TICK, se;
  logic RING_ACTIVE_STATUS, CRYSTAL_AMP_DISABLE, CRYSTAL_READY;
  logic [11:0] PADDR = '0;
  logic [31:0] PWDATA = '0, PRDATA, rd;
  logic [1:0] DIVIDER_ACTIVE, rxen = '0;
  logic [2:0] lvl = '0;
  logic [3:0] act = '0;
  logic [4:0] ev = '0; // tx1 write, tx0 write, start1, start0, irq
  int n_errors = 0;
  int tests_run = 0;
  pmcu_top #(.WARMUP(WU)) i_pmcu_top (.CLK_SYS, .RESET_N, .PSEL, .PENABLE, .PWRITE, .PADDR,
    .PWDATA, .PRDATA, .PREADY, .PSLVERR, .XTAL_OSC_RUNNING, .EXT_IRQ_PENDING(ev[0]),
    .EXT_IRQ_HIGH_PRIO(hp), .POWERFAIL_LEVEL_ACTIVE(lvl[2]), .HIGH_LEVEL_ACTIVE(lvl[1]),
    .LOW_LEVEL_ACTIVE(lvl[0]), .SERIAL0_RX_ENABLE(rxen[0]), .SERIAL1_RX_ENABLE(rxen[1]),
    .SERIAL0_START_EDGE(ev[1]), .SERIAL1_START_EDGE(ev[2]), .SERIAL0_TX_BUFFER_WRITE(ev[3]),
    .SERIAL1_TX_BUFFER_WRITE(ev[4]), .SERIAL0_RX_ACTIVE(act[0]), .SERIAL0_TX_ACTIVE(act[1]),
    .SERIAL1_RX_ACTIVE(act[2]), .SERIAL1_TX_ACTIVE(act[3]), .CYCLE_TICK, .DIVIDER_ACTIVE,
    .RING_ACTIVE_STATUS, .CRYSTAL_AMP_DISABLE, .CRYSTAL_READY);
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge CLK_SYS);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK_SYS);
    PENABLE <= 1'b1;
    do @(posedge CLK_SYS); while (PREADY !== 1'b1);
    rd = PRDATA;
    se = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic wdiv(input logic [1:0] e);
    for (int i = 0; i < 1100 && DIVIDER_ACTIVE !== e; i++) @(posedge CLK_SYS);
    chk("divider", 32'(DIVIDER_ACTIVE), 32'(e));
  endtask
  task automatic gap(input int e);
    int n;
    n = 1;
    while (CYCLE_TICK !== 1'b1) @(posedge CLK_SYS);
    @(posedge CLK_SYS);
    while (CYCLE_TICK !== 1'b1) begin
      n++;
      @(posedge CLK_SYS);
    end
    chk("tick gap", n, e);
  endtask
  task automatic t_reset;
    chk("divider", 32'(DIVIDER_ACTIVE), 32'(DIV_4));
    apb(1'b0, ADDR_EXTENDED_IRQ_FLAG_CLOCK_CLK, '0);
    chk("flags", rd, 32'h0000_0008);
    apb(1'b0, ADDR_PM_CTRL, '0);
    chk("pm", rd, 32'h0000_0040);
    lvl <= 3'b101;
    act <= 4'b1010;
    apb(1'b1, ADDR_SVC_STAT, 32'h0000_00ff);
    apb(1'b0, ADDR_SVC_STAT, '0);
    chk("status", rd, 32'h0000_00ba);
    lvl <= 3'b010;
    act <= 4'b0101;
    apb(1'b0, ADDR_SVC_STAT, '0);
    chk("status", rd, 32'h0000_0055);
    lvl <= '0;
    act <= '0;
    apb(1'b0, 12'h000, '0);
    chk("slverr", 32'(se), 32'h0000_0001);
  endtask
  task automatic t_div;
    apb(1'b1, ADDR_PM_CTRL, 32'h0000_0080);
    chk("early", 32'(DIVIDER_ACTIVE), 32'(DIV_4));
    wdiv(DIV_64);
    gap(64);
    apb(1'b1, ADDR_PM_CTRL, 32'h0000_00c0);
    apb(1'b1, ADDR_PM_CTRL, 32'h0000_0000);
    apb(1'b0, ADDR_PM_CTRL, '0);
    chk("kept", rd, 32'h0000_0080);
    apb(1'b1, ADDR_PM_CTRL, 32'h0000_0040);
    chk("early", 32'(DIVIDER_ACTIVE), 32'(DIV_64));
    wdiv(DIV_4);
    apb(1'b1, ADDR_PM_CTRL, 32'h0000_00c0);
    wdiv(DIV_1024);
    gap(1024);
    apb(1'b1, ADDR_PM_CTRL, 32'h0000_0040);
    wdiv(DIV_4);
  endtask
  task automatic ret(input logic [4:0] e, input logic [1:0] r, input logic [2:0] l,
      input logic h, input logic back);
    rxen <= r;
    lvl <= l;
    hp <= h;
    apb(1'b1, ADDR_PM_CTRL, 32'h0000_0060);
    apb(1'b0, ADDR_SVC_STAT, '0);
    chk("serial idle", rd & 32'h0000_000f, 32'h0000_0000);
    apb(1'b1, ADDR_PM_CTRL, 32'h0000_00a0);
    wdiv(DIV_64);
    ev <= e;
    @(posedge CLK_SYS);
    ev <= '0;
    apb(1'b0, ADDR_PM_CTRL, '0);
    chk("return", rd, back ? 32'h0000_0060 : 32'h0000_00a0);
    apb(1'b1, ADDR_PM_CTRL, 32'h0000_0040);
    wdiv(DIV_4);
  endtask
  task automatic t_auto;
    ret(5'b00001, 2'b00, 3'b000, 1'b0, 1'b1);
    ret(5'b00001, 2'b00, 3'b001, 1'b0, 1'b0);
    ret(5'b00001, 2'b00, 3'b001, 1'b1, 1'b1);
    ret(5'b00001, 2'b00, 3'b010, 1'b1, 1'b0);
    ret(5'b00010, 2'b01, 3'b000, 1'b0, 1'b1);
    ret(5'b00010, 2'b10, 3'b000, 1'b0, 1'b0);
    ret(5'b00100, 2'b10, 3'b000, 1'b0, 1'b1);
    ret(5'b01000, 2'b00, 3'b000, 1'b0, 1'b1);
    ret(5'b10000, 2'b00, 3'b000, 1'b0, 1'b1);
  endtask
  task automatic t_xtal;
    int n;
    apb(1'b1, ADDR_PM_CTRL, 32'h0000_0048);
    apb(1'b0, ADDR_PM_CTRL, '0);
    chk("amp off refused", rd, 32'h0000_0040);
    apb(1'b1, ADDR_EXTENDED_IRQ_FLAG_CLOCK_CLK, '0);
    repeat (6) @(posedge CLK_SYS);
    chk("ring", 32'(RING_ACTIVE_STATUS), 32'h0000_0001);
    apb(1'b1, ADDR_PM_CTRL, 32'h0000_0048);
    XTAL_OSC_RUNNING <= 1'b0;
    // amplifier gate shows one edge after the write, ready one edge later
    repeat (2) @(posedge CLK_SYS);
    chk("amp off", 32'(CRYSTAL_AMP_DISABLE), 32'h0000_0001);
    chk("ready", 32'(CRYSTAL_READY), 32'h0000_0000);
    apb(1'b1, ADDR_EXTENDED_IRQ_FLAG_CLOCK_CLK, 32'h0000_0008);
    apb(1'b0, ADDR_EXTENDED_IRQ_FLAG_CLOCK_CLK, '0);
    chk("xtal refused", rd, 32'h0000_0004);
    ret(5'b00010, 2'b01, 3'b000, 1'b0, 1'b1);
    chk("ring kept", 32'(RING_ACTIVE_STATUS), 32'h0000_0001);
    chk("no oscillation", 32'(CRYSTAL_READY), 32'h0000_0000);
    XTAL_OSC_RUNNING <= 1'b1;
    for (n = 0; n < 100 && CRYSTAL_READY !== 1'b1; n++) @(posedge CLK_SYS);
    // synchroniser adds a few clocks on top of the warm-up count
    chk("warm-up", 32'(n >= WU && n <= WU + 8), 32'h0000_0001);
    apb(1'b1, ADDR_EXTENDED_IRQ_FLAG_CLOCK_CLK, 32'h0000_0008);
    repeat (6) @(posedge CLK_SYS);
    apb(1'b0, ADDR_EXTENDED_IRQ_FLAG_CLOCK_CLK, '0);
    chk("crystal", rd, 32'h0000_0008);
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    CLK_SYS = 1'b0;
    forever #12.5 CLK_SYS = ~CLK_SYS;
  end
  initial begin
    repeat (10) @(posedge CLK_SYS);
    RESET_N <= 1'b1;
    t_reset;
    t_div;
    t_auto;
    t_xtal;
    results;
  end
  // the full run needs well under 8000 clocks
  initial begin
    repeat (20000) @(posedge CLK_SYS);
    n_errors++;
    results;
  end
endmodule
